// [design/boot_loader_pkg.sv]
// Shared constants, enumerations and carrier structs of the serial bootstrap loader.
// Assumes a single 100 MHz core clock and a 32-bit Avalon-MM register bus.
package boot_loader_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAL = 8'h08;
  localparam logic [7:0] OFS_FDV = 8'h0C;
  localparam logic [7:0] OFS_BG = 8'h10;
  localparam logic [7:0] OFS_ERR = 8'h14;

  // Field positions in the control and status registers.
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_STATE_POS = 0;
  localparam int STAT_DONE_POS = 4;
  localparam int STAT_COUNT_POS = 8;
  localparam int STAT_FERR_POS = 16;
  localparam logic CTRL_EN_RESET = 1'b1;

  // Bit positions of the synchronised boot pins.
  localparam int PIN_RST = 4;
  localparam int PIN_P04 = 3;
  localparam int PIN_P03 = 2;
  localparam int PIN_TEST = 1;
  localparam int PIN_RXD = 0;

  // Calibration and divider search arithmetic.
  localparam logic [1:0] T6_PRESCALE_LAST = 2'h3;
  localparam logic [15:0] CAL_MAX = 16'hFFFF;
  localparam logic [25:0] ROUND_HALF = 26'h000_2400;
  localparam logic [25:0] BG_DIVISOR = 26'h000_4800;
  localparam int ERR_SHIFT = 10;
  localparam logic [9:0] FDV_FIRST = 10'h100;
  localparam logic [9:0] FDV_LAST = 10'h200;

  // Serial framing counts.
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TX_FRAME_BITS = 4'hA;
  localparam logic [2:0] RX_BIT_LAST = 3'h7;
  localparam logic [5:0] LOAD_BYTES = 6'h20;

  // Identification byte; the value is arbitrary.
  localparam logic [7:0] ID_BYTE = 8'h5A;

  // Addresses and hand-over values.
  localparam logic [23:0] LOAD_BASE = 24'h00_FA40;
  localparam logic [23:0] LOAD_LAST = 24'h00_FA5F;
  localparam logic [23:0] BOOTROM_LAST = 24'h00_7FFF;
  localparam logic [15:0] CP_VAL = 16'hFA00;
  localparam logic [15:0] SP_VAL = 16'hFA40;
  localparam logic [15:0] STACK_UNDERFLOW_LIMIT_VAL = 16'hFA40;
  localparam logic [15:0] STACK_OVERFLOW_LIMIT_VAL = 16'hFA20;
  localparam logic [15:0] SERIAL_CTRL_VAL = 16'h8011;

  // Loader sequence states.
  typedef enum logic [2:0] {
    BS_IDLE, BS_CAL_WAIT, BS_CAL_MEASURE, BS_SEARCH, BS_SEND_ID, BS_LOAD, BS_DONE
  } boot_state_t;

  // Receive frame states.
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } av_req_t;

  // Avalon-MM answer of the slave.
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } av_rsp_t;

  // Byte write port into internal RAM.
  typedef struct packed {
    logic we;
    logic [23:0] addr;
    logic [7:0] data;
  } ram_wr_t;

  // Core fetch request to be routed.
  typedef struct packed {
    logic code;
    logic data;
    logic [23:0] addr;
  } fetch_req_t;

  // Configuration left behind for the loaded program.
  typedef struct packed {
    logic wdt_disable;
    logic [15:0] context_pointer;
    logic [15:0] stack_pointer;
    logic [15:0] stack_underflow_limit;
    logic [15:0] stack_overflow_limit;
    logic [15:0] serial_ctrl_reg;
    logic [8:0] frac_divider_reg;
    logic [12:0] baud_reload_reg;
    logic tx_buffer_request_flag;
    logic transmit_pin_level;
    logic transmit_pin_direction_bit;
  } handover_cfg_t;

endpackage

// [design/divider_search.sv]
// Sequential search over fractional divider values for the best baud reload.
// Latches the measured count on start, so later changes of t6 do not affect the search.
module divider_search
  import boot_loader_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Search request.
  input wire logic start,
  input wire logic [15:0] t6,
  // Search result.
  output logic done,
  output logic [9:0] best_fdv,
  output logic [12:0] best_bg,
  output logic [15:0] best_err
);

  // Whole state of the search.
  typedef struct packed {
    logic busy;
    logic have;
    logic done;
    logic [15:0] t6;
    logic [9:0] frac_div_value;
    logic [9:0] best_fdv;
    logic [12:0] best_bg;
    logic [15:0] best_err;
  } srch_t;

  srch_t st_r;
  srch_t st_nxt;
  logic [25:0] prod;
  logic [25:0] num;
  logic [14:0] rem;
  logic [13:0] diff;
  logic [23:0] err;
  logic trial_ok;

  // One trial per cycle: reload, remainder and graded error.
  always_comb begin
    prod = 26'(st_r.t6) * 26'(st_r.frac_div_value);
    trial_ok = prod >= ROUND_HALF;
    num = prod - ROUND_HALF;
    rem = 15'(num % BG_DIVISOR);
    diff = (rem >= 15'(ROUND_HALF)) ? 14'(rem - 15'(ROUND_HALF)) : 14'(15'(ROUND_HALF) - rem);
    err = ((24'(diff) << ERR_SHIFT) + 24'(st_r.frac_div_value >> 1)) / 24'(st_r.frac_div_value);
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      st_nxt.busy = 1'b1;
      st_nxt.have = 1'b0;
      st_nxt.t6 = t6;
      st_nxt.frac_div_value = FDV_FIRST;
    end else if (st_r.busy) begin
      // Strictly smaller error wins, so ties keep the lower divider.
      if (trial_ok && (!st_r.have || 16'(err) < st_r.best_err)) begin
        st_nxt.have = 1'b1;
        st_nxt.best_fdv = st_r.frac_div_value;
        st_nxt.best_bg = 13'(num / BG_DIVISOR);
        st_nxt.best_err = 16'(err);
      end
      if (st_r.frac_div_value == FDV_LAST) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.frac_div_value = st_r.frac_div_value + 10'h001;
      end
    end
  end

  // State register with clock enable.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
  assign best_fdv = st_r.best_fdv;
  assign best_bg = st_r.best_bg;
  assign best_err = st_r.best_err;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Trials stay inside the allowed divider range.
  trial_range_a: assert property (st_r.busy |-> st_r.frac_div_value >= FDV_FIRST && st_r.frac_div_value <= FDV_LAST)
    else $error("divider trial outside range");
  // The search ends only after the last divider was tried.
  search_end_a: assert property (done |-> $past(st_r.frac_div_value) == FDV_LAST && best_fdv >= FDV_FIRST)
    else $error("search ended early");
  // A kept pair always satisfies the reload equation.
  reload_pair_a: assert property (done && st_r.have |->
    (26'(st_r.t6) * 26'(best_fdv) - ROUND_HALF) / BG_DIVISOR == 26'(best_bg))
    else $error("kept reload does not match kept divider");

endmodule // divider_search

// [design/serial_bootstrap_loader.sv]
// Serial bootstrap loader: strap-gated entry, autobaud, identification, 32-byte load, jump.
// Assumes asynchronous boot pins, a 100 MHz mclk, and an Avalon-MM master that holds requests.
//
// Overview of operation
// - Enter only on strapped hardware reset release.
// - Measure zero byte with clock-by-four timer.
// - Reload is (count*divider-9216)/18432 with remainder.
// - Error from remainder distance, shifted, over divider.
// - Try dividers 256..512, keep least error.
// - Best divider 512 is written as zero.
// - Rate is divider*f/(512*16*(reload+1)).
// - Set 8N1, enable generators, drive transmit high.
// - Send one identification byte.
// - Wait for exactly 32 bytes, no timeout.
// - Store bytes in order at FA40..FA5F.
// - Jump to FA40 after last byte, no reset.
// - Leave watchdog off, fixed pointer and stack limits.
// - Leave serial setup, request flag, pin high.
// - Interrupts and error resets blocked during loading.
// - Low code fetches go to boot ROM.
module serial_bootstrap_loader
  import boot_loader_pkg::*;
(
  // Clock, reset and enable.
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM register slave.
  input wire av_req_t av_req,
  output av_rsp_t av_rsp,
  // Boot pins, asynchronous to mclk.
  input wire logic hw_reset_input_n,
  input wire logic strap_p0_4,
  input wire logic strap_p0_3,
  input wire logic test_pin,
  input wire logic rxd,
  // Serial transmit pin.
  output logic txd,
  output logic txd_oe,
  // Write port into internal RAM.
  output ram_wr_t ram_wr,
  // Hand-over to the core.
  output logic jump_req,
  output logic [23:0] jump_addr,
  output handover_cfg_t handover,
  output logic irq_block,
  output logic err_reset_block,
  // Fetch routing.
  input wire fetch_req_t fetch,
  output logic bootrom_sel,
  output logic data_undef
);

  // Whole state of the loader.
  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic hw_rst_seen;
    logic strap_ok;
    logic ctrl_en;
    boot_state_t bs;
    rx_state_t rxs;
    logic [1:0] pre;
    logic [15:0] t6;
    logic search_go;
    logic baud_en;
    logic [8:0] acc;
    logic [12:0] bg_cnt;
    logic [3:0] tx_div;
    logic [3:0] rx_div;
    logic [9:0] tx_shift;
    logic [3:0] tx_cnt;
    logic txd;
    logic txd_oe;
    logic [7:0] rx_byte;
    logic [2:0] rx_bit;
    logic [5:0] byte_cnt;
    logic [7:0] frame_errs;
    logic [15:0] best_err;
    ram_wr_t ram;
    logic jump;
    logic [23:0] jump_addr;
    handover_cfg_t hand;
    logic irq_block;
    logic err_block;
    logic bootrom_sel;
    logic data_undef;
    av_rsp_t rsp;
  } state_t;

  // Value of the state after reset.
  localparam state_t ST_RESET = '{bs: BS_IDLE, rxs: RX_IDLE, ctrl_en: CTRL_EN_RESET,
    rsp: '{readdata: 32'h0000_0000, waitrequest: 1'b1}, default: '0};

  state_t st_r;
  state_t st_nxt;
  logic rx_in; // Synchronised receive line.
  logic rst_pin_n; // Synchronised hardware reset pin.
  logic tick16; // Sixteen-times oversampling tick.
  logic bit_tick; // Transmit bit boundary.
  logic [9:0] fdv_eff; // Divider with zero meaning 512.
  logic [9:0] acc_sum; // Fractional accumulator sum.
  logic [31:0] rd_word; // Register read data.
  logic srch_done; // Search finished pulse.
  logic [9:0] srch_fdv; // Best divider found.
  logic [12:0] srch_bg; // Best reload found.
  logic [15:0] srch_err; // Best graded error.

  // Only the second synchroniser stage is read by logic.
  assign rx_in = st_r.sync2[PIN_RXD];
  assign rst_pin_n = st_r.sync2[PIN_RST];

  // Search engine over divider values.
  divider_search u_search (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .start(st_r.search_go),
    .t6(st_r.t6),
    .done(srch_done),
    .best_fdv(srch_fdv),
    .best_bg(srch_bg),
    .best_err(srch_err)
  );

  // Register read multiplexer; unmapped offsets read zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (av_req.address)
      OFS_CTRL: rd_word[CTRL_EN_BIT] = st_r.ctrl_en;
      OFS_STATUS: begin
        rd_word[STAT_STATE_POS +: 3] = st_r.bs;
        rd_word[STAT_DONE_POS] = (st_r.bs == BS_DONE);
        rd_word[STAT_COUNT_POS +: 6] = st_r.byte_cnt;
        rd_word[STAT_FERR_POS +: 8] = st_r.frame_errs;
      end
      OFS_CAL: rd_word[15:0] = st_r.t6;
      OFS_FDV: rd_word[8:0] = st_r.hand.frac_divider_reg;
      OFS_BG: rd_word[12:0] = st_r.hand.baud_reload_reg;
      OFS_ERR: rd_word[15:0] = st_r.best_err;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next-state logic for the whole loader.
  always_comb begin
    st_nxt = st_r;
    tick16 = 1'b0;
    acc_sum = 10'h000;
    fdv_eff = (st_r.hand.frac_divider_reg == 9'h000) ? FDV_LAST : {1'b0, st_r.hand.frac_divider_reg};
    // Two-stage synchronisers on every pin.
    st_nxt.sync1 = {hw_reset_input_n, strap_p0_4, strap_p0_3, test_pin, rxd};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.jump = 1'b0;
    st_nxt.ram.we = 1'b0;
    st_nxt.search_go = 1'b0;
    // Code fetches from the low range select the boot ROM.
    st_nxt.bootrom_sel = fetch.code && (fetch.addr <= BOOTROM_LAST);
    st_nxt.data_undef = fetch.data && (fetch.addr <= BOOTROM_LAST);
    // Fractional divider feeds the reload counter, giving the oversampling tick.
    if (st_r.baud_en) begin
      acc_sum = 10'(st_r.acc) + fdv_eff;
      st_nxt.acc = acc_sum[8:0];
      if (acc_sum[9]) begin
        if (st_r.bg_cnt == 13'h0000) begin
          st_nxt.bg_cnt = st_r.hand.baud_reload_reg;
          tick16 = 1'b1;
        end else begin
          st_nxt.bg_cnt = st_r.bg_cnt - 13'h0001;
        end
      end
    end
    if (tick16) begin
      st_nxt.tx_div = st_r.tx_div + 4'h1;
    end
    bit_tick = tick16 && (st_r.tx_div == TICK_LAST);
    // Bus slave: one wait cycle, then the access completes.
    if (st_r.rsp.waitrequest) begin
      if (av_req.read || av_req.write) begin
        st_nxt.rsp.waitrequest = 1'b0;
        st_nxt.rsp.readdata = av_req.read ? rd_word : 32'h0000_0000;
      end
    end else begin
      st_nxt.rsp.waitrequest = 1'b1;
      if (av_req.write && av_req.address == OFS_CTRL) begin
        st_nxt.ctrl_en = av_req.writedata[CTRL_EN_BIT];
      end
    end
    // Hardware reset pin: hold idle, capture straps, start on release.
    if (!rst_pin_n) begin
      st_nxt.hw_rst_seen = 1'b1;
      st_nxt.strap_ok = !st_r.sync2[PIN_P04] && st_r.sync2[PIN_P03] && !st_r.sync2[PIN_TEST];
      st_nxt.bs = BS_IDLE;
    end else if (st_r.hw_rst_seen) begin
      st_nxt.hw_rst_seen = 1'b0;
      if (st_r.strap_ok && st_r.ctrl_en) begin
        st_nxt.bs = BS_CAL_WAIT;
        st_nxt.hand = '0;
        st_nxt.hand.wdt_disable = 1'b1;
        st_nxt.irq_block = 1'b1;
        st_nxt.err_block = 1'b1;
        st_nxt.baud_en = 1'b0;
        st_nxt.txd_oe = 1'b0;
        st_nxt.frame_errs = 8'h00;
        st_nxt.byte_cnt = 6'h00;
      end
    end else begin
      unique case (st_r.bs)
        BS_IDLE: begin
          st_nxt.bs = BS_IDLE;
        end
        // Wait for the start bit of the zero byte.
        BS_CAL_WAIT: begin
          if (!rx_in) begin
            st_nxt.bs = BS_CAL_MEASURE;
            st_nxt.t6 = 16'h0000;
            st_nxt.pre = 2'h0;
          end
        end
        // Count at a quarter of the clock until the line returns high.
        BS_CAL_MEASURE: begin
          if (rx_in) begin
            st_nxt.bs = BS_SEARCH;
            st_nxt.search_go = 1'b1;
          end else begin
            st_nxt.pre = st_r.pre + 2'h1;
            if (st_r.pre == T6_PRESCALE_LAST && st_r.t6 != CAL_MAX) begin
              st_nxt.t6 = st_r.t6 + 16'h0001;
            end
          end
        end
        // Take the search result and set up the serial channel.
        BS_SEARCH: begin
          if (srch_done) begin
            st_nxt.hand.frac_divider_reg = (srch_fdv == FDV_LAST) ? 9'h000 : srch_fdv[8:0];
            st_nxt.hand.baud_reload_reg = srch_bg;
            st_nxt.hand.serial_ctrl_reg = SERIAL_CTRL_VAL;
            st_nxt.hand.transmit_pin_level = 1'b1;
            st_nxt.hand.transmit_pin_direction_bit = 1'b1;
            st_nxt.best_err = srch_err;
            st_nxt.baud_en = 1'b1;
            st_nxt.acc = 9'h000;
            st_nxt.bg_cnt = 13'h0000;
            st_nxt.tx_div = 4'h0;
            st_nxt.txd = 1'b1;
            st_nxt.txd_oe = 1'b1;
            st_nxt.tx_shift = {1'b1, ID_BYTE, 1'b0};
            st_nxt.tx_cnt = 4'h0;
            st_nxt.bs = BS_SEND_ID;
          end
        end
        // Shift out start bit, identification byte and stop bit.
        BS_SEND_ID: begin
          if (bit_tick) begin
            if (st_r.tx_cnt == TX_FRAME_BITS) begin
              st_nxt.bs = BS_LOAD;
              st_nxt.rxs = RX_IDLE;
              st_nxt.byte_cnt = 6'h00;
            end else begin
              st_nxt.txd = st_r.tx_shift[0];
              st_nxt.tx_shift = {1'b1, st_r.tx_shift[9:1]};
              st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
            end
          end
        end
        // Receive code bytes until 32 have been stored; no timeout.
        BS_LOAD: begin
          unique case (st_r.rxs)
            RX_IDLE: begin
              if (!rx_in) begin
                st_nxt.rxs = RX_START;
                st_nxt.rx_div = 4'h0;
              end
            end
            RX_START: begin
              if (tick16) begin
                st_nxt.rx_div = st_r.rx_div + 4'h1;
                if (st_r.rx_div == TICK_HALF) begin
                  st_nxt.rx_div = 4'h0;
                  st_nxt.rx_bit = 3'h0;
                  st_nxt.rxs = rx_in ? RX_IDLE : RX_DATA;
                end
              end
            end
            RX_DATA: begin
              if (tick16) begin
                st_nxt.rx_div = st_r.rx_div + 4'h1;
                if (st_r.rx_div == TICK_LAST) begin
                  st_nxt.rx_byte = {rx_in, st_r.rx_byte[7:1]};
                  st_nxt.rx_bit = st_r.rx_bit + 3'h1;
                  if (st_r.rx_bit == RX_BIT_LAST) begin
                    st_nxt.rxs = RX_STOP;
                  end
                end
              end
            end
            RX_STOP: begin
              if (tick16) begin
                st_nxt.rx_div = st_r.rx_div + 4'h1;
                if (st_r.rx_div == TICK_LAST) begin
                  // A low stop bit is counted but the byte is kept.
                  if (!rx_in) begin
                    st_nxt.frame_errs = st_r.frame_errs + 8'h01;
                  end
                  st_nxt.ram.we = 1'b1;
                  st_nxt.ram.addr = LOAD_BASE + 24'(st_r.byte_cnt);
                  st_nxt.ram.data = st_r.rx_byte;
                  st_nxt.byte_cnt = st_r.byte_cnt + 6'h01;
                  st_nxt.rxs = RX_IDLE;
                  if (st_r.byte_cnt == LOAD_BYTES - 6'h01) begin
                    st_nxt.bs = BS_DONE;
                    st_nxt.jump = 1'b1;
                    st_nxt.jump_addr = LOAD_BASE;
                    st_nxt.hand.context_pointer = CP_VAL;
                    st_nxt.hand.stack_pointer = SP_VAL;
                    st_nxt.hand.stack_underflow_limit = STACK_UNDERFLOW_LIMIT_VAL;
                    st_nxt.hand.stack_overflow_limit = STACK_OVERFLOW_LIMIT_VAL;
                    st_nxt.hand.tx_buffer_request_flag = 1'b1;
                    st_nxt.irq_block = 1'b0;
                    st_nxt.err_block = 1'b0;
                  end
                end
              end
            end
          endcase
        end
        BS_DONE: begin
          st_nxt.bs = BS_DONE;
        end
        default: begin
          st_nxt.bs = BS_IDLE;
        end
      endcase
    end
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign av_rsp = st_r.rsp;
  assign txd = st_r.txd;
  assign txd_oe = st_r.txd_oe;
  assign ram_wr = st_r.ram;
  assign jump_req = st_r.jump;
  assign jump_addr = st_r.jump_addr;
  assign handover = st_r.hand;
  assign irq_block = st_r.irq_block;
  assign err_reset_block = st_r.err_block;
  assign bootrom_sel = st_r.bootrom_sel;
  assign data_undef = st_r.data_undef;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Start of the identification frame and its stop bit.
  sequence id_start_s;
    st_r.bs == BS_SEND_ID && bit_tick && ce && st_r.tx_cnt == 4'h0;
  endsequence
  sequence id_stop_s;
    st_r.bs == BS_SEND_ID && bit_tick && ce && st_r.tx_cnt == 4'h9;
  endsequence

  entry_gate_a: assert property ((st_r.bs == BS_CAL_WAIT && $past(st_r.bs) == BS_IDLE) |->
    $past(st_r.strap_ok) && $past(st_r.ctrl_en))
    else $error("loader entered without strap conditions");
  t6_rate_a: assert property ((st_r.bs == BS_CAL_MEASURE && $past(st_r.bs) == BS_CAL_MEASURE &&
    st_r.t6 != $past(st_r.t6)) |-> $past(st_r.pre) == T6_PRESCALE_LAST && st_r.t6 == $past(st_r.t6) + 16'h0001)
    else $error("calibration timer stepped at wrong rate");
  zero_map_a: assert property ((st_r.bs == BS_SEND_ID && $past(st_r.bs) == BS_SEARCH) |->
    ((st_r.hand.frac_divider_reg == 9'h000) == ($past(srch_fdv) == FDV_LAST)))
    else $error("divider 512 not written as zero");
  serial_setup_a: assert property ((st_r.bs == BS_SEND_ID || st_r.bs == BS_LOAD) |->
    st_r.hand.serial_ctrl_reg == SERIAL_CTRL_VAL && st_r.baud_en && txd_oe)
    else $error("serial channel not set up");
  id_start_a: assert property (id_start_s |=> !txd)
    else $error("identification start bit missing");
  id_stop_a: assert property (id_stop_s |=> txd)
    else $error("identification stop bit missing");
  load_count_a: assert property (jump_req |-> st_r.byte_cnt == LOAD_BYTES && st_r.bs == BS_DONE)
    else $error("jump before 32 bytes");
  ram_range_a: assert property (ram_wr.we |-> ram_wr.addr >= LOAD_BASE && ram_wr.addr <= LOAD_LAST &&
    ram_wr.addr == LOAD_BASE + 24'(st_r.byte_cnt) - 24'h00_0001)
    else $error("code byte stored out of order");
  jump_target_a: assert property (jump_req |-> jump_addr == LOAD_BASE ##1 !jump_req)
    else $error("jump target or pulse wrong");
  handover_cfg_a: assert property (st_r.bs == BS_DONE && !$past(rst) |-> handover.wdt_disable &&
    handover.context_pointer == CP_VAL && handover.stack_pointer == SP_VAL &&
    handover.stack_overflow_limit == STACK_OVERFLOW_LIMIT_VAL && handover.tx_buffer_request_flag && txd)
    else $error("hand-over configuration wrong");
  irq_hold_a: assert property ((st_r.bs != BS_IDLE && st_r.bs != BS_DONE) |-> irq_block && err_reset_block)
    else $error("interrupts not blocked while loading");
  rom_route_a: assert property ((ce && fetch.code && fetch.addr <= BOOTROM_LAST) |=> bootrom_sel)
    else $error("low code fetch not routed to boot ROM");

endmodule // serial_bootstrap_loader

// [verification/host_link.sv]
// Host end of the boot link: sends and receives 8N1 frames.
// Assumes the bench calls its tasks; BIT is the bit time in mclk cycles.
module host_link (
  // Clock.
  input wire logic mclk,
  // Device transmit pin.
  input wire logic txd,
  input wire logic txd_oe,
  // Device receive pin.
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 160; // Fast enough to keep the count small.
  initial rxd = 1'b1; // The line idles high between frames.
  // Sends one frame, start bit first, then data from the LSB.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask
  // Waits for a start bit and samples each data bit in its middle.
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while ((txd !== 1'b0 || txd_oe !== 1'b1) && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    ok = n < 9000;
    repeat (BIT + BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      b[i] = txd;
      repeat (BIT) @(posedge mclk);
    end
  endtask
endmodule // host_link

// [verification/serial_bootstrap_loader_test.sv]
// Bench for the loader: strap entry, autobaud, ID, 32-byte load, hand-over.
// Assumes the host_link model on the serial pins and a 100 MHz clock.
module serial_bootstrap_loader_test import boot_loader_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, ce, hw_n, p04, p03, tst, rxd, txd, txd_oe, jump_req, irq_block, erb, rom, und, ok;
  av_req_t av_req;
  av_rsp_t av_rsp;
  ram_wr_t ram_wr;
  fetch_req_t fetch;
  handover_cfg_t ho;
  logic [23:0] jump_addr;
  logic [31:0] d;
  logic [7:0] b;
  int err_count = 0, n_checks = 0, idx = 0, p;
  serial_bootstrap_loader dut_u (.mclk(mclk), .rst(rst), .ce(ce), .av_req(av_req), .av_rsp(av_rsp),
    .hw_reset_input_n(hw_n), .strap_p0_4(p04), .strap_p0_3(p03), .test_pin(tst), .rxd(rxd), .txd(txd),
    .txd_oe(txd_oe), .ram_wr(ram_wr), .jump_req(jump_req), .jump_addr(jump_addr), .handover(ho),
    .irq_block(irq_block), .err_reset_block(erb), .fetch(fetch), .bootrom_sel(rom), .data_undef(und));
  host_link host (.mclk(mclk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Prints the verdict and stops.
  task automatic complete_run();
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One Avalon-MM access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    av_req <= '{read: !w, write: w, address: a, writedata: wd};
    do begin
      @(posedge mclk);
      n++;
    end while (av_rsp.waitrequest !== 1'b0 && n < 50);
    rd = av_rsp.readdata;
    av_req <= '0;
    // One idle edge keeps a following call from reassigning the request in this step.
    @(posedge mclk);
    if (n >= 50) begin
      err_count++;
      complete_run();
    end
  endtask
  // Pulses the board reset pin with the given test pin level.
  task automatic pin_reset(input logic t);
    tst <= t;
    hw_n <= 1'b0;
    repeat (5) @(posedge mclk);
    hw_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask
  // Checks every stored byte and the jump that comes in the same cycle as the last one.
  always @(posedge mclk) begin
    if (ram_wr.we === 1'b1) begin
      chk({ram_wr.addr, ram_wr.data}, {LOAD_BASE + 24'(idx), 8'(idx * 37 + 5)});
      idx++;
    end
    if (jump_req === 1'b1) begin
      chk({8'(idx), jump_addr}, {8'd32, LOAD_BASE});
      chk(32'(ho.stack_underflow_limit - ho.stack_overflow_limit), 32'h0000_0020);
      chk({ho.context_pointer, ho.stack_pointer}, {CP_VAL, SP_VAL});
      chk({ho.stack_underflow_limit, ho.stack_overflow_limit}, {STACK_UNDERFLOW_LIMIT_VAL, STACK_OVERFLOW_LIMIT_VAL});
      chk({ho.tx_buffer_request_flag, ho.transmit_pin_level, ho.transmit_pin_direction_bit}, 3'b111);
    end
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    complete_run();
  end
  initial begin
    {rst, ce, hw_n, p04, p03, tst} = 6'b111011;
    av_req = '0;
    fetch = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    pin_reset(1'b1);
    bus(1'b0, OFS_STATUS, 0, d);
    chk(d[2:0], 0);
    bus(1'b1, OFS_CTRL, 1, d);
    pin_reset(1'b0);
    bus(1'b0, OFS_STATUS, 0, d);
    chk({d[2:0], irq_block, erb, ho.wdt_disable}, 6'o17);
    fetch <= '{code: 1'b1, data: 1'b0, addr: BOOTROM_LAST};
    @(posedge mclk);
    fetch <= '{code: 1'b0, data: 1'b1, addr: 24'h00_0000};
    @(posedge mclk);
    chk({rom, und}, 2'b10);
    fetch <= '0;
    @(posedge mclk);
    chk({rom, und}, 2'b01);
    host.send_byte(8'h00);
    host.recv_byte(b, ok);
    chk({ok, b, txd_oe, ho.serial_ctrl_reg}, {1'b1, ID_BYTE, 1'b1, SERIAL_CTRL_VAL});
    bus(1'b0, OFS_CAL, 0, d);
    chk(32'(d > 357 && d < 364), 1);
    p = 8192 * (ho.baud_reload_reg + 1) / (ho.frac_divider_reg == 0 ? 512 : ho.frac_divider_reg);
    chk(32'(p > 155 && p < 165 && ho.frac_divider_reg < 512), 1);
    repeat (320) @(posedge mclk);
    for (int k = 0; k < 32; k++) host.send_byte(8'(k * 37 + 5));
    repeat (40) @(posedge mclk);
    bus(1'b0, OFS_STATUS, 0, d);
    chk({d[13:8], 26'(idx)}, {6'd32, 26'd32});
    bus(1'b0, 8'h18, 0, d);
    chk(d, 0);
    complete_run();
  end
endmodule // serial_bootstrap_loader_test
